/* design/ltc_pkg.sv */
// Purpose: Shared constants and types for the light threshold block
// Assumes: 16-bit registers reached through an I2C target, 8-bit pointer
// Notes: Threshold words carry a 4-bit exponent over a 12-bit mantissa
package ltc_pkg;
	// Register word and pointer widths
	localparam int REG_W = 16;
	localparam int PTR_W = 8;
	localparam int EXP_W = 4;
	localparam int MANT_W = 12;
	localparam int EXP_LSB = 12;
	localparam int POW_W = MANT_W + 15;

	// Register pointers
	localparam logic [PTR_W-1:0] ADDR_RESULT = 8'h00;
	localparam logic [PTR_W-1:0] ADDR_CONFIG = 8'h01;
	localparam logic [PTR_W-1:0] ADDR_LOW_THR = 8'h02;
	localparam logic [PTR_W-1:0] ADDR_HIGH_THR = 8'h03;

	// Configuration field positions
	localparam int CFG_ABOVE_BIT = 6;
	localparam int CFG_BELOW_BIT = 5;
	localparam int CFG_LATCH_BIT = 4;
	localparam int CFG_POL_BIT = 3;
	localparam int CFG_ME_BIT = 2;
	localparam int CFG_FC_LSB = 0;
	localparam int CFG_FC_W = 2;

	// Reset values
	localparam logic CFG_LATCH_RST = 1'b1;
	localparam logic CFG_POL_RST = 1'b0;
	localparam logic CFG_ME_RST = 1'b0;
	localparam logic [CFG_FC_W-1:0] CFG_FC_RST = 2'h0;
	localparam logic [REG_W-1:0] LOW_THR_RST = 16'h0000;

	// Range code at and above which the exponent is never masked
	localparam logic [EXP_W-1:0] RANGE_AUTO = 4'hC;
	localparam logic [EXP_W-1:0] EXP_MASKED = 4'h0;
	// Largest fault count selectable, counters saturate here
	localparam int FAULT_SAT = 8;

	// I2C target states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_ACK = 6'h04,
		ST_WR = 6'h08,
		ST_RD = 6'h10,
		ST_MACK = 6'h20
	} ltc_i2c_state_e;

	// Optical power in LSB units of 1.2 nW/cm2: mantissa shifted by exponent
	function automatic logic [POW_W-1:0] ltc_to_power(
		input logic [REG_W-1:0] word
	);
		ltc_to_power = POW_W'(word[MANT_W-1:0]) << word[REG_W-1:EXP_LSB];
	endfunction : ltc_to_power
endpackage : ltc_pkg

/* design/ltc_i2c_target.sv */
// Purpose: I2C target giving 16-bit register access by an 8-bit pointer
// Assumes: SCL and SDA already synchronous to ref_clk_i, well oversampled
// Notes: Write is pointer then MSB, LSB; read streams MSB, LSB repeatedly
`timescale 1ns/10ps
`default_nettype none
module ltc_i2c_target #(
	parameter logic [6:0] DEV_ADDR = 7'h44
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic [ltc_pkg::PTR_W-1:0] reg_ptr_o,
	output logic wr_stb_o,
	output logic [ltc_pkg::REG_W-1:0] wr_data_o,
	output logic rd_stb_o,
	input wire logic [ltc_pkg::REG_W-1:0] rd_data_i
);
	import ltc_pkg::*;

	ltc_i2c_state_e st_reg, st_next;
	logic scl_reg, sda_reg, done_reg, done_next, oe_reg, oe_next;
	logic rw_reg, rw_next, bsel_reg, bsel_next, nack_reg, nack_next;
	logic wr_reg, wr_next, rd_fire;
	logic [2:0] cnt_reg, cnt_next;
	logic [1:0] bidx_reg, bidx_next;
	logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next, msb_reg, msb_next;
	logic [REG_W-1:0] word_reg, word_next, wdat_reg, wdat_next;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	// Line events from the previous samples
	assign scl_rise = scl_i & ~scl_reg;
	assign scl_fall = ~scl_i & scl_reg;
	assign bus_start = scl_i & scl_reg & sda_reg & ~sda_i;
	assign bus_stop = scl_i & scl_reg & ~sda_reg & sda_i;

	// Protocol sequencing and shift logic
	always_comb begin
		logic [7:0] byte_v;
		byte_v = 8'h00;
		st_next = st_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		done_next = done_reg;
		oe_next = oe_reg;
		rw_next = rw_reg;
		bidx_next = bidx_reg;
		ptr_next = ptr_reg;
		msb_next = msb_reg;
		word_next = word_reg;
		wdat_next = wdat_reg;
		bsel_next = bsel_reg;
		nack_next = nack_reg;
		wr_next = 1'b0;
		rd_fire = 1'b0;
		if (bus_start) begin
			st_next = ST_ADDR;
			cnt_next = 3'h0;
			done_next = 1'b0;
			oe_next = 1'b0;
		end else if (bus_stop) begin
			st_next = ST_IDLE;
			oe_next = 1'b0;
		end else begin
			case (st_reg)
				ST_ADDR, ST_WR: begin
					if (scl_rise) begin
						sh_next = {sh_reg[6:0], sda_i};
						cnt_next = cnt_reg + 3'h1;
						done_next = (cnt_reg == 3'h7);
					end else if (scl_fall && done_reg) begin
						done_next = 1'b0;
						oe_next = 1'b1;
						st_next = ST_ACK;
						if (st_reg == ST_ADDR) begin
							if (sh_reg[7:1] == DEV_ADDR) begin
								rw_next = sh_reg[0];
								bidx_next = 2'h0;
								bsel_next = 1'b0;
								rd_fire = sh_reg[0];
								if (sh_reg[0]) begin
									word_next = rd_data_i;
								end
							end else begin
								oe_next = 1'b0;
								st_next = ST_IDLE;
							end
						end else if (bidx_reg == 2'h0) begin
							ptr_next = sh_reg;
							bidx_next = 2'h1;
						end else if (bidx_reg == 2'h1) begin
							msb_next = sh_reg;
							bidx_next = 2'h2;
						end else begin
							wr_next = 1'b1;
							wdat_next = {msb_reg, sh_reg};
							bidx_next = 2'h1;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rw_reg) begin
							byte_v = word_reg[15:8];
							oe_next = ~byte_v[7];
							sh_next = {byte_v[6:0], 1'b0};
							cnt_next = 3'h1;
							st_next = ST_RD;
						end else begin
							oe_next = 1'b0;
							cnt_next = 3'h0;
							st_next = ST_WR;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (cnt_reg == 3'h0) begin
							oe_next = 1'b0;
							st_next = ST_MACK;
						end else begin
							oe_next = ~sh_reg[7];
							sh_next = {sh_reg[6:0], 1'b0};
							cnt_next = cnt_reg + 3'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						nack_next = sda_i;
					end else if (scl_fall) begin
						if (nack_reg) begin
							st_next = ST_IDLE;
						end else begin
							bsel_next = ~bsel_reg;
							byte_v = bsel_reg ? word_reg[15:8] : word_reg[7:0];
							oe_next = ~byte_v[7];
							sh_next = {byte_v[6:0], 1'b0};
							cnt_next = 3'h1;
							st_next = ST_RD;
						end
					end
				end
				default: begin
					oe_next = 1'b0;
				end
			endcase
		end
	end

	// Protocol state registers
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_reg <= ST_IDLE;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			cnt_reg <= 3'h0;
			sh_reg <= 8'h00;
			done_reg <= 1'b0;
			oe_reg <= 1'b0;
			rw_reg <= 1'b0;
			bidx_reg <= 2'h0;
			ptr_reg <= 8'h00;
			msb_reg <= 8'h00;
			word_reg <= 16'h0000;
			wdat_reg <= 16'h0000;
			bsel_reg <= 1'b0;
			nack_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			scl_reg <= scl_i;
			sda_reg <= sda_i;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			done_reg <= done_next;
			oe_reg <= oe_next;
			rw_reg <= rw_next;
			bidx_reg <= bidx_next;
			ptr_reg <= ptr_next;
			msb_reg <= msb_next;
			word_reg <= word_next;
			wdat_reg <= wdat_next;
			bsel_reg <= bsel_next;
			nack_reg <= nack_next;
			wr_reg <= wr_next;
		end
	end

	// Open-drain data line only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_reg;
	assign reg_ptr_o = ptr_reg;
	assign wr_stb_o = wr_reg;
	assign wr_data_o = wdat_reg;
	assign rd_stb_o = rd_fire;
endmodule : ltc_i2c_target
`default_nettype wire

/* design/ltc_threshold_irq.sv */
// Purpose: Limit comparison, fault persistence and alert pin for a light
//          sensor, with configuration and low limit reached over I2C
// Assumes: Conversion engine supplies each result with a one-cycle valid
// Notes: Range and high limit live outside and arrive as inputs
// Functional notes
// - Latch bit 0: alert and flags follow the live limit comparison.
// - Latch bit 1 (reset): alert and flags hold until host clears them.
// - Polarity 0 (default): an interrupt pulls the alert pin low.
// - Polarity 1: pin released on interrupt, held low otherwise.
// - Mask bit set and range below 1100b: result exponent reads 0000b.
// - Masking touches only the result read; comparisons use raw result.
// - Fault count 00/01/10/11 needs 1/2/4/8 consecutive faults; reset 00.
// - Low limit is a read/write register at pointer 02h.
// - Low limit: exponent bits 15-12, mantissa bits 11-0, both reset zero.
// - Low limit power is 1.2 nW/cm2 times two to exponent times mantissa.
// - Each exponent step doubles full scale and LSB weight.
// - Result and limits compared as optical power, exponents may differ.
// - Above flag sets after enough consecutive results over high limit.
// - Below flag sets after enough consecutive results under low limit.
`timescale 1ns/10ps
`default_nettype none
module ltc_threshold_irq #(
	parameter logic [6:0] DEV_ADDR = 7'h44,
	parameter int FAULT_CNT_W = 4
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic alert_o,
	output logic alert_oe_o,
	input wire logic [ltc_pkg::REG_W-1:0] result_i,
	input wire logic result_valid_i,
	input wire logic [ltc_pkg::EXP_W-1:0] range_code_i,
	input wire logic [ltc_pkg::REG_W-1:0] high_thr_i,
	output logic above_ind_o,
	output logic below_ind_o
);
	import ltc_pkg::*;

	// Counter must hold the largest fault count
	generate
		if (FAULT_CNT_W < 4) begin : g_bad_width
			$error("FAULT_CNT_W too small for eight fault counts");
		end
	endgenerate

	// Saturation keeps a long fault run from wrapping below the need
	localparam logic [FAULT_CNT_W-1:0] CNT_SAT = FAULT_CNT_W'(FAULT_SAT);

	logic [PTR_W-1:0] reg_ptr;
	logic wr_stb, rd_stb, cfg_wr, cfg_rd, low_wr;
	logic [REG_W-1:0] wr_data, rd_data;

	// Serial register port
	ltc_i2c_target #(
		.DEV_ADDR(DEV_ADDR)
	) u_i2c (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o),
		.reg_ptr_o(reg_ptr),
		.wr_stb_o(wr_stb),
		.wr_data_o(wr_data),
		.rd_stb_o(rd_stb),
		.rd_data_i(rd_data)
	);

	// Access decode
	assign cfg_wr = wr_stb && (reg_ptr == ADDR_CONFIG);
	assign cfg_rd = rd_stb && (reg_ptr == ADDR_CONFIG);
	assign low_wr = wr_stb && (reg_ptr == ADDR_LOW_THR);

	// Configuration and limit storage
	logic latch_reg, latch_next, pol_reg, pol_next, me_reg, me_next;
	logic [CFG_FC_W-1:0] fc_reg, fc_next;
	logic [REG_W-1:0] low_thr_reg, low_thr_next, result_reg, result_next;

	// Next values of the host-written fields and the captured result
	always_comb begin
		latch_next = latch_reg;
		pol_next = pol_reg;
		me_next = me_reg;
		fc_next = fc_reg;
		low_thr_next = low_thr_reg;
		result_next = result_reg;
		if (cfg_wr) begin
			latch_next = wr_data[CFG_LATCH_BIT];
			pol_next = wr_data[CFG_POL_BIT];
			me_next = wr_data[CFG_ME_BIT];
			fc_next = wr_data[CFG_FC_LSB +: CFG_FC_W];
		end
		if (low_wr) begin
			low_thr_next = wr_data;
		end
		if (result_valid_i) begin
			result_next = result_i;
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			latch_reg <= CFG_LATCH_RST;
			pol_reg <= CFG_POL_RST;
			me_reg <= CFG_ME_RST;
			fc_reg <= CFG_FC_RST;
			low_thr_reg <= LOW_THR_RST;
			result_reg <= 16'h0000;
		end else begin
			latch_reg <= latch_next;
			pol_reg <= pol_next;
			me_reg <= me_next;
			fc_reg <= fc_next;
			low_thr_reg <= low_thr_next;
			result_reg <= result_next;
		end
	end

	// Limit comparison on power values, raw exponent used throughout
	logic [POW_W-1:0] res_pow, low_pow, high_pow;
	logic is_above, is_below;
	assign res_pow = ltc_to_power(result_i);
	assign low_pow = ltc_to_power(low_thr_reg);
	assign high_pow = ltc_to_power(high_thr_i);
	assign is_above = res_pow > high_pow;
	assign is_below = res_pow < low_pow;

	// Fault persistence and flag state
	logic [FAULT_CNT_W-1:0] hi_cnt_reg, hi_cnt_next, lo_cnt_reg, lo_cnt_next;
	logic [FAULT_CNT_W-1:0] hi_inc, lo_inc, need;
	logic above_reg, above_next, below_reg, below_next, hi_trig, lo_trig;

	// One, two, four or eight consecutive faults from the count field
	assign need = FAULT_CNT_W'(1) << fc_reg;
	assign hi_inc = (hi_cnt_reg == CNT_SAT) ? hi_cnt_reg : hi_cnt_reg + 1'b1;
	assign lo_inc = (lo_cnt_reg == CNT_SAT) ? lo_cnt_reg : lo_cnt_reg + 1'b1;
	assign hi_trig = is_above && (hi_inc >= need);
	assign lo_trig = is_below && (lo_inc >= need);

	// Clear by config read first so a same-cycle trigger wins
	always_comb begin
		hi_cnt_next = hi_cnt_reg;
		lo_cnt_next = lo_cnt_reg;
		above_next = above_reg;
		below_next = below_reg;
		if (latch_reg && cfg_rd) begin
			above_next = 1'b0;
			below_next = 1'b0;
		end
		// Counters move only on a measurement, a clear leaves them alone
		if (result_valid_i) begin
			hi_cnt_next = is_above ? hi_inc : '0;
			lo_cnt_next = is_below ? lo_inc : '0;
			if (latch_reg) begin
				above_next = above_next | hi_trig;
				below_next = below_next | lo_trig;
			end else begin
				above_next = hi_trig;
				below_next = lo_trig;
			end
		end
	end

	// Flag registers
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hi_cnt_reg <= '0;
			lo_cnt_reg <= '0;
			above_reg <= 1'b0;
			below_reg <= 1'b0;
		end else begin
			hi_cnt_reg <= hi_cnt_next;
			lo_cnt_reg <= lo_cnt_next;
			above_reg <= above_next;
			below_reg <= below_next;
		end
	end

	// Alert pin: open drain, polarity chooses which state is driven low
	logic alert_act;
	assign alert_act = above_reg | below_reg;
	assign alert_o = 1'b0;
	assign alert_oe_o = alert_act ^ pol_reg;
	assign above_ind_o = above_reg;
	assign below_ind_o = below_reg;

	// Register read mux, unmapped pointers read zero
	always_comb begin
		rd_data = 16'h0000;
		case (reg_ptr)
			ADDR_RESULT: begin
				rd_data = result_reg;
				if (me_reg && (range_code_i < RANGE_AUTO)) begin
					rd_data[REG_W-1:EXP_LSB] = EXP_MASKED;
				end
			end
			ADDR_CONFIG: begin
				rd_data[CFG_ABOVE_BIT] = above_reg;
				rd_data[CFG_BELOW_BIT] = below_reg;
				rd_data[CFG_LATCH_BIT] = latch_reg;
				rd_data[CFG_POL_BIT] = pol_reg;
				rd_data[CFG_ME_BIT] = me_reg;
				rd_data[CFG_FC_LSB +: CFG_FC_W] = fc_reg;
			end
			ADDR_LOW_THR: begin
				rd_data = low_thr_reg;
			end
			ADDR_HIGH_THR: begin
				rd_data = high_thr_i;
			end
			default: begin
				rd_data = 16'h0000;
			end
		endcase
	end

	// Checks on alert drive
	chk_alert_low_pol: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) !pol_reg |-> (alert_oe_o == alert_act))
		else $error("alert not pulled low while active with polarity 0");
	chk_alert_inverted: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) pol_reg |-> (alert_oe_o == !alert_act))
		else $error("alert drive not inverted with polarity 1");

	// Checks on reporting style
	chk_live_follow: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (!latch_reg && result_valid_i) |=>
		(above_reg == $past(hi_trig)) && (below_reg == $past(lo_trig)))
		else $error("transparent flags do not follow comparison");
	chk_latch_hold: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (latch_reg && above_reg && !cfg_rd) |=>
		above_reg [*1] ##0 (!cfg_wr || $past(latch_reg)))
		else $error("latched above flag dropped without a clear");
	chk_latch_clear: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (latch_reg && cfg_rd && !result_valid_i) |=>
		(!above_reg && !below_reg && !alert_act))
		else $error("configuration read did not clear latched flags");

	// Checks on result masking
	chk_mask_exp: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (reg_ptr == ADDR_RESULT && me_reg &&
		range_code_i < RANGE_AUTO) |->
		(rd_data == {EXP_MASKED, result_reg[MANT_W-1:0]}))
		else $error("result exponent not masked");
	chk_unmasked_read: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (reg_ptr == ADDR_RESULT &&
		(!me_reg || range_code_i >= RANGE_AUTO)) |-> (rd_data == result_reg))
		else $error("result exponent masked when it should not be");

	// Checks on limit storage and persistence
	chk_low_write: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) low_wr |=>
		(low_thr_reg == $past(wr_data)) ##1 (low_thr_reg == $past(wr_data, 2)
		|| low_wr || $past(low_wr)))
		else $error("low limit write not stored");
	chk_count_restart: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (result_valid_i && !is_above && !is_below)
		|=> (hi_cnt_reg == '0) && (lo_cnt_reg == '0))
		else $error("persistence counter not restarted");
	chk_above_count: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) $rose(above_reg) |->
		($past(hi_inc) >= $past(need)) && $past(is_above))
		else $error("above flag set before enough faults");
	chk_below_count: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) $rose(below_reg) |->
		($past(lo_inc) >= $past(need)) && $past(is_below))
		else $error("below flag set before enough faults");

	// Checks on configuration storage
	chk_cfg_write: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) cfg_wr |=>
		(fc_reg == $past(wr_data[CFG_FC_LSB +: CFG_FC_W])) &&
		(latch_reg == $past(wr_data[CFG_LATCH_BIT])) &&
		(pol_reg == $past(wr_data[CFG_POL_BIT])) &&
		(me_reg == $past(wr_data[CFG_ME_BIT])))
		else $error("configuration write not stored");

	// Checks on counters and flag steadiness
	chk_count_sat: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (hi_cnt_reg <= CNT_SAT) &&
		(lo_cnt_reg <= CNT_SAT))
		else $error("persistence counter past its limit");
	chk_alert_flags: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (above_ind_o || below_ind_o) ==
		(alert_oe_o != pol_reg))
		else $error("alert drive disagrees with flags");
	chk_flag_quiet: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (!result_valid_i && !cfg_rd) |=>
		$stable(above_reg) && $stable(below_reg))
		else $error("flags moved without a result or a clear");
	chk_below_early: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) (result_valid_i && !latch_reg &&
		is_below && (lo_inc < need)) |=> !below_reg)
		else $error("below flag set before enough faults counted");
endmodule : ltc_threshold_irq
`default_nettype wire

/* dv/ltc_host_model.sv */
// Purpose: Host processor model: I2C controller plus alert pin pull-up
// Assumes: SCL and SDA change only at ref_clk_i edges, 8 clocks per half
// Notes: Open-drain wires read 1 unless some party pulls them low
`timescale 1ns/10ps
`default_nettype none
module ltc_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h44
) (
	input wire logic ref_clk_i,
	input wire logic dev_sda_oe_i,
	input wire logic dev_alert_oe_i,
	output logic scl_o,
	output logic sda_o,
	output logic alert_pin_o
);
	logic sda_pull;
	// Wired-AND of the SDA pull-up with both pulling parties
	assign sda_o = ~(sda_pull | dev_sda_oe_i);
	// Alert line has a pull-up, low only while the device pulls it
	assign alert_pin_o = ~dev_alert_oe_i;
	// Bus idle at time zero
	initial begin
		scl_o = 1'b1;
		sda_pull = 1'b0;
	end
	// Let a number of clock edges pass
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : tick
	// One bit out, SDA moved only while SCL is low
	task automatic bit_out(input logic b);
		sda_pull <= ~b;
		tick(4);
		scl_o <= 1'b1;
		tick(8);
		scl_o <= 1'b0;
		tick(4);
	endtask : bit_out
	// One bit in, sampled in the middle of SCL high
	task automatic bit_in(output logic b);
		sda_pull <= 1'b0;
		tick(4);
		scl_o <= 1'b1;
		tick(4);
		b = sda_o;
		tick(4);
		scl_o <= 1'b0;
		tick(4);
	endtask : bit_in
	// Byte out MSB first, then the target's acknowledge
	task automatic byte_out(input logic [7:0] v, output logic ack);
		logic nack;
		for (int i = 7; i >= 0; i--) begin
			bit_out(v[i]);
		end
		bit_in(nack);
		ack = ~nack;
	endtask : byte_out
	// Byte in MSB first, then our acknowledge or not
	task automatic byte_in(input logic ack, output logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			bit_in(v[i]);
		end
		bit_out(~ack);
	endtask : byte_in
	// START: SDA falls while SCL is high
	task automatic start_cond();
		sda_pull <= 1'b0;
		tick(4);
		sda_pull <= 1'b1;
		tick(8);
		scl_o <= 1'b0;
		tick(4);
	endtask : start_cond
	// STOP: SDA rises while SCL is high
	task automatic stop_cond();
		sda_pull <= 1'b1;
		tick(4);
		scl_o <= 1'b1;
		tick(8);
		sda_pull <= 1'b0;
		tick(8);
	endtask : stop_cond
	// Pointer then one 16-bit word, MSB first
	task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d,
			output logic ok);
		logic a0, a1, a2, a3;
		start_cond();
		byte_out({DEV_ADDR, 1'b0}, a0);
		byte_out(ptr, a1);
		byte_out(d[15:8], a2);
		byte_out(d[7:0], a3);
		stop_cond();
		ok = a0 & a1 & a2 & a3;
	endtask : write_reg
	// Pointer set by a write, then a read of one word ending in NACK
	task automatic read_reg(input logic [7:0] ptr, output logic [15:0] d,
			output logic ok);
		logic a0, a1, a2;
		start_cond();
		byte_out({DEV_ADDR, 1'b0}, a0);
		byte_out(ptr, a1);
		stop_cond();
		start_cond();
		byte_out({DEV_ADDR, 1'b1}, a2);
		byte_in(1'b1, d[15:8]);
		byte_in(1'b0, d[7:0]);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : read_reg
endmodule : ltc_host_model
`default_nettype wire

/* dv/test_ltc_threshold_irq.sv */
// Purpose: Self-checking bench for the light threshold block
// Assumes: Host model drives the I2C wires, bench drives measurements
// Notes: Expected flags worked out from mantissa shifted by exponent
`timescale 1ns/10ps
`default_nettype none
module test_ltc_threshold_irq;
	import ltc_pkg::*;
	logic ref_clk_i, reset_n_i, scl, sda_wire, sda_drv, sda_oe;
	logic alert_drv, alert_oe, alert_pin, result_valid_i, above, below;
	logic [REG_W-1:0] result_i, high_thr_i, rd;
	logic [EXP_W-1:0] range_code_i;
	logic ok;
	int errors, samples_checked;
	// Device under test
	ltc_threshold_irq uut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.scl_i(scl), .sda_i(sda_wire), .sda_o(sda_drv), .sda_oe_o(sda_oe),
		.alert_o(alert_drv), .alert_oe_o(alert_oe), .result_i(result_i),
		.result_valid_i(result_valid_i), .range_code_i(range_code_i),
		.high_thr_i(high_thr_i), .above_ind_o(above), .below_ind_o(below));
	// Host side of the I2C port and alert line
	ltc_host_model host (.ref_clk_i(ref_clk_i), .dev_sda_oe_i(sda_oe),
		.dev_alert_oe_i(alert_oe), .scl_o(scl), .sda_o(sda_wire),
		.alert_pin_o(alert_pin));
	// 200 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	// Counts and verdict, the single end of the run
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	// Compare one value, four-state exact
	task automatic chk(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Compare above, below and alert drive together
	task automatic chk_flags(input logic [2:0] e);
		chk("flags", {13'h0000, e}, {13'h0000, above, below, alert_oe});
	endtask : chk_flags
	// Register write through the host, acknowledged throughout
	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		@(posedge ref_clk_i);
		host.write_reg(p, d, ok);
		chk("write ack", 16'h0001, {15'h0000, ok});
	endtask : wr
	// Register read through the host and compare
	task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
		@(posedge ref_clk_i);
		host.read_reg(p, rd, ok);
		chk("read ack", 16'h0001, {15'h0000, ok});
		chk("read data", e, rd);
	endtask : rd_chk
	// One measurement pulse; flags settled on return
	task automatic meas(input logic [15:0] w);
		@(posedge ref_clk_i);
		result_i <= w;
		result_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		result_valid_i <= 1'b0;
		#1;
	endtask : meas
	// Hang guard
	initial begin
		repeat (90000) @(posedge ref_clk_i);
		errors++;
		$display("BAD watchdog expected end seen hang");
		give_verdict();
	end
	// Main sequence
	initial begin
		errors = 0;
		samples_checked = 0;
		reset_n_i = 1'b0;
		result_i = 16'h0000;
		result_valid_i = 1'b0;
		range_code_i = 4'h0;
		high_thr_i = 16'hBFFF;
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		@(posedge ref_clk_i);
		#1;
		chk_flags(3'b000);
		chk("drive levels", 16'h0000, {14'h0000, sda_drv, alert_drv});
		rd_chk(ADDR_CONFIG, 16'h0010);
		rd_chk(ADDR_LOW_THR, 16'h0000);
		wr(ADDR_LOW_THR, 16'hA5C3);
		rd_chk(ADDR_LOW_THR, 16'hA5C3);
		rd_chk(8'h04, 16'h0000);
		// Low limit 100h LSB steps of weight 2: power 0200h units
		wr(ADDR_LOW_THR, 16'h1100);
		wr(ADDR_CONFIG, 16'h0000);
		meas(16'h01FF);
		chk_flags(3'b011);
		chk("alert pin", 16'h0000, {15'h0000, alert_pin});
		meas(16'h0200);
		chk_flags(3'b000);
		meas(16'h207F);
		chk_flags(3'b011);
		meas(16'h2080);
		chk_flags(3'b000);
		// High limit at exponent Bh: power 0800h units
		@(posedge ref_clk_i) high_thr_i <= 16'hB001;
		meas(16'h0801);
		chk_flags(3'b101);
		meas(16'hB001);
		chk_flags(3'b000);
		rd_chk(ADDR_HIGH_THR, 16'hB001);
		// Every fault count, with a restart in the middle
		for (int f = 0; f < 4; f++) begin
			wr(ADDR_CONFIG, 16'(f));
			meas(16'h0400);
			repeat ((1 << f) - 1) meas(16'h0001);
			chk_flags(3'b000);
			meas(16'h0400);
			repeat ((1 << f) - 1) meas(16'h0001);
			chk_flags(3'b000);
			meas(16'h0001);
			chk_flags(3'b011);
			meas(16'h0400);
			chk_flags(3'b000);
		end
		// Latched mode holds until a configuration read
		wr(ADDR_CONFIG, 16'h0010);
		meas(16'h0900);
		chk_flags(3'b101);
		meas(16'h0400);
		chk_flags(3'b101);
		rd_chk(ADDR_CONFIG, 16'h0050);
		chk_flags(3'b000);
		// Inverted alert: held low when quiet, released on interrupt
		wr(ADDR_CONFIG, 16'h0008);
		meas(16'h0400);
		chk_flags(3'b001);
		chk("alert pin", 16'h0000, {15'h0000, alert_pin});
		meas(16'h0001);
		chk_flags(3'b010);
		chk("alert pin", 16'h0001, {15'h0000, alert_pin});
		rd_chk(ADDR_CONFIG, 16'h0028);
		// Exponent mask hits the result read only
		wr(ADDR_CONFIG, 16'h0004);
		@(posedge ref_clk_i) range_code_i <= 4'hB;
		meas(16'h3050);
		chk_flags(3'b000);
		rd_chk(ADDR_RESULT, 16'h0050);
		@(posedge ref_clk_i) range_code_i <= 4'hC;
		rd_chk(ADDR_RESULT, 16'h3050);
		@(posedge ref_clk_i) range_code_i <= 4'hB;
		wr(ADDR_CONFIG, 16'h0000);
		rd_chk(ADDR_RESULT, 16'h3050);
		give_verdict();
	end
endmodule : test_ltc_threshold_irq
`default_nettype wire
